/* core/pex_core.v */
// Function
// - scl input only, sda pulled low only
// - start, address, rw, bytes, stop
// - detect start and stop conditions
// - one bit per clock, stable high
// - ninth clock acknowledge by receiver
// - answer only prefix 110 plus straps
// - rw low write, high read
// - read byte one is port levels
// - read byte two is old flags
// - longer reads alternate resampled pairs
// - alert held off during reads until stop
// - port byte sampled at preceding ack
// - read match acks, snapshots, releases alert
// - master nack takes no snapshot
// - compare against new snapshot until next capture
// - write match acks, snapshots, releases alert
// - each written byte sets all ports
// - input change sets flag, alert low
// - straps pick defaults and pullups
// - four-level pins encode address bits
`timescale 1ns/1ps
`include "pex_defs.vh"

module pex_core #(
  parameter PORTS = 8
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // two-wire bus pins
  input wire i_scl,
  input wire i_sda,
  output wire o_sda_o,
  output wire o_sda_oe,
  // serial interface reset pin, active low
  input wire i_serial_rst_b,
  // four-level address select pins
  input wire [1:0] i_high_addr_select_pin,
  input wire [1:0] i_low_addr_select_pin,
  // io port pins, open drain
  input wire [PORTS-1:0] i_io_port_pins,
  output wire [PORTS-1:0] o_io_port_pins_o,
  output wire [PORTS-1:0] o_io_port_pins_oe,
  output wire [PORTS-1:0] o_pullup_en,
  // port update acceptance from the output stage
  input wire i_out_ready,
  // change alert, open drain, active low
  output wire o_change_alert_o,
  output wire o_change_alert_oe
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_WACK = 3'h4;
  localparam ST_RDAT = 3'h5;
  localparam ST_RACK = 3'h6;
  localparam ST_WAIT = 3'h7;

  // high pin maps to address bits 3:2
  function [1:0] hi_bits;
    input [1:0] lvl;
    begin
      case (lvl)
        `PEX_PIN_SCL: hi_bits = `PEX_HI_SCL;
        `PEX_PIN_SDA: hi_bits = `PEX_HI_SDA;
        `PEX_PIN_GND: hi_bits = `PEX_HI_GND;
        default: hi_bits = `PEX_HI_VCC;
      endcase
    end
  endfunction

  // synchronisers, first stage read only by the second
  reg [1:0] scl_m_q, sda_m_q, srst_m_q;
  reg [3:0] strap_m_q, strap_q;
  reg [PORTS-1:0] port_m_q, port_q;
  reg scl_q, sda_q, srst_b_q, scl_d1_q, sda_d1_q;

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_m_q <= 2'h3;
      sda_m_q <= 2'h3;
      srst_m_q <= 2'h3;
      strap_m_q <= 4'h0;
      port_m_q <= {PORTS{1'b1}};
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      srst_b_q <= 1'b1;
      strap_q <= 4'h0;
      port_q <= {PORTS{1'b1}};
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_m_q <= {scl_m_q[0], i_scl};
      sda_m_q <= {sda_m_q[0], i_sda};
      srst_m_q <= {srst_m_q[0], i_serial_rst_b};
      strap_m_q <= {i_high_addr_select_pin, i_low_addr_select_pin};
      port_m_q <= i_io_port_pins;
      scl_q <= scl_m_q[1];
      sda_q <= sda_m_q[1];
      srst_b_q <= srst_m_q[1];
      strap_q <= strap_m_q;
      port_q <= port_m_q;
      scl_d1_q <= scl_q;
      sda_d1_q <= sda_q;
    end
  end

  // bus events from the sampled lines
  wire scl_rise = scl_q & ~scl_d1_q;
  wire scl_fall = ~scl_q & scl_d1_q;
  wire bus_start = scl_q & scl_d1_q & sda_d1_q & ~sda_q;
  wire bus_stop = scl_q & scl_d1_q & ~sda_d1_q & sda_q;

  // address built from both select pins; low pin code is its bits
  wire [6:0] my_addr = {`PEX_ADDR_PREFIX, hi_bits(strap_q[3:2]),
    strap_q[1:0]};

  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] rx_q, tx_q;
  reg sda_oe_q, rd_act_q, pair_q, mack_q, alert_q, strap_done_q;
  reg [PORTS-1:0] snap_q, flags_q, flags_old_q, out_q, pull_q;
  reg [1:0] strap_cnt_q;
  reg wr_push, capture;

  // write buffer between the bus and the port latch
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;

  pex_buf2 #(
    .WIDTH(8),
    .DEPTH(2),
    .AW(1)
  ) u_wbuf (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(wr_push),
    .i_in_data(rx_q),
    .o_in_ready(buf_in_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(i_out_ready)
  );

  // ports released high are the ones watched as inputs
  wire [PORTS-1:0] change = (port_q ^ snap_q) & out_q;

  // events decided combinationally from the bus engine state
  always @* begin
    wr_push = 1'b0;
    capture = 1'b0;
    if (srst_b_q && !bus_start && !bus_stop && scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          capture = (bit_cnt_q == `PEX_BYTE_BITS) &&
            (rx_q[7:1] == my_addr);
        end
        ST_WDAT: begin
          wr_push = (bit_cnt_q == `PEX_BYTE_BITS) && buf_in_ready;
        end
        ST_RACK: begin
          capture = mack_q & ~pair_q;
        end
        default: begin
          capture = 1'b0;
        end
      endcase
    end
  end

  // bus engine; sda changes only just after scl falls, or when serial reset releases it
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      sda_oe_q <= 1'b0;
      rd_act_q <= 1'b0;
      pair_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (!srst_b_q || bus_stop) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_WDAT: begin
          if (scl_rise) begin
            rx_q <= {rx_q[6:0], sda_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `PEX_BYTE_BITS) begin
            if (state_q == ST_ADDR) begin
              if (capture) begin
                state_q <= ST_AACK;
                sda_oe_q <= 1'b1;
                rd_act_q <= rx_q[0];
              end else begin
                state_q <= ST_WAIT;
              end
            end else if (buf_in_ready) begin
              state_q <= ST_WACK;
              sda_oe_q <= 1'b1;
            end else begin
              state_q <= ST_WAIT; // full buffer: byte not acked
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rd_act_q) begin
              state_q <= ST_RDAT;
              tx_q <= snap_q;
              sda_oe_q <= ~snap_q[7];
              pair_q <= 1'b0;
            end else begin
              state_q <= ST_WDAT;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_q <= ST_WDAT;
            sda_oe_q <= 1'b0;
            bit_cnt_q <= 4'h0;
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == `PEX_BYTE_BITS) begin
              state_q <= ST_RACK;
              sda_oe_q <= 1'b0;
              pair_q <= ~pair_q;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_q;
          end else if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (!mack_q) begin
              state_q <= ST_WAIT;
            end else if (pair_q) begin
              state_q <= ST_RDAT;
              tx_q <= flags_old_q;
              sda_oe_q <= ~flags_old_q[7];
            end else begin
              state_q <= ST_RDAT;
              tx_q <= port_q;
              sda_oe_q <= ~port_q[7];
            end
          end
        end
        ST_WAIT: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // snapshot, transition flags and change alert; a change in the
  // capture cycle still reaches the flags handed to the reader
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      snap_q <= {PORTS{1'b1}};
      flags_q <= {PORTS{1'b0}};
      flags_old_q <= {PORTS{1'b0}};
      alert_q <= 1'b0;
    end else if (capture) begin
      snap_q <= port_q;
      flags_old_q <= flags_q | change;
      flags_q <= {PORTS{1'b0}};
      alert_q <= 1'b0;
    end else begin
      flags_q <= flags_q | change;
      // held off while a read runs; raised at its stop
      if (rd_act_q ? (bus_stop && (|(flags_q | change))) : (|change)) begin
        alert_q <= 1'b1;
      end
    end
  end

  // strap sampling a few cycles after release, then written bytes
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      out_q <= `PEX_OUT_RST;
      pull_q <= `PEX_PULL_RST;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == `PEX_STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        out_q <= {{4{strap_q[3:2] != `PEX_PIN_GND}},
          {4{strap_q[1:0] != `PEX_PIN_GND}}};
        pull_q <= {{4{strap_q[3:2] != `PEX_PIN_GND}},
          {4{strap_q[1:0] != `PEX_PIN_GND}}};
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end else if (buf_out_valid && i_out_ready) begin
      out_q <= buf_out_data;
    end
  end

  // open-drain drives: only ever pull low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_q;
  assign o_io_port_pins_o = {PORTS{1'b0}};
  assign o_io_port_pins_oe = ~out_q;
  assign o_pullup_en = pull_q;
  assign o_change_alert_o = 1'b0;
  assign o_change_alert_oe = alert_q;

endmodule // pex_core

/* core/pex_defs.vh */
`ifndef PEX_DEFS_VH
`define PEX_DEFS_VH

// fixed upper three address bits (bit6, bit5, bit4)
`define PEX_ADDR_PREFIX 3'b110

// sensed level of a four-level address select pin
`define PEX_PIN_GND 2'h0
`define PEX_PIN_VCC 2'h1
`define PEX_PIN_SCL 2'h2
`define PEX_PIN_SDA 2'h3

// address bit pairs for the high select pin
`define PEX_HI_SCL 2'h0
`define PEX_HI_SDA 2'h1
`define PEX_HI_GND 2'h2
`define PEX_HI_VCC 2'h3

// reset values before the straps are taken
`define PEX_OUT_RST 8'hff
`define PEX_PULL_RST 8'h00

// cycles after reset release before straps are taken
`define PEX_STRAP_WAIT 2'h3

// bits per byte on the wire, ack excluded
`define PEX_BYTE_BITS 4'h8

`endif

/* core/pex_buf2.v */
`timescale 1ns/1ps
`include "pex_defs.vh"

module pex_buf2 #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // fill side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // drain side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // honest full and empty from the entry count
  assign o_in_ready = (count_q != DEPTH[AW:0]);
  assign o_out_valid = (count_q != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // storage has no reset; only pointers and the count need a defined state
  always @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= i_in_data;
    end
  end

  // pointers wrap at depth
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        if (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) begin
          wr_ptr_q <= {AW{1'b0}};
        end else begin
          wr_ptr_q <= wr_ptr_q + 1'b1;
        end
      end
      if (pop) begin
        if (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) begin
          rd_ptr_q <= {AW{1'b0}};
        end else begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
        end
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // pex_buf2

/* test/pex_core_props.sv */
`timescale 1ns/1ps
module pex_core_props #(
  parameter PORTS = 8
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // bus pins
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_o,
  input wire o_sda_oe,
  input wire i_serial_rst_b,
  // straps
  input wire [1:0] i_high_addr_select_pin,
  input wire [1:0] i_low_addr_select_pin,
  // ports and alert
  input wire [PORTS-1:0] i_io_port_pins,
  input wire [PORTS-1:0] o_io_port_pins_o,
  input wire [PORTS-1:0] o_io_port_pins_oe,
  input wire [PORTS-1:0] o_pullup_en,
  input wire i_out_ready,
  input wire o_change_alert_o,
  input wire o_change_alert_oe
);
  // cycles since reset, saturating; straps have landed by the top
  reg [3:0] up_q;
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hf) begin
      up_q <= up_q + 4'h1;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  property p_sda_low;
    o_sda_o == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda high");

  property p_hold;
    i_scl && $past(i_scl) |-> $stable(o_sda_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("sda moved");

  property p_rise_low;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_rise_low: assert property (p_rise_low) else $error("pull late");

  property p_pull_width;
    $rose(o_sda_oe) |-> o_sda_oe [*8];
  endproperty
  a_pull_width: assert property (p_pull_width) else $error("short");

  property p_srst;
    !i_serial_rst_b [*5] |-> !o_sda_oe;
  endproperty
  a_srst: assert property (p_srst) else $error("sda held");

  property p_pullup;
    up_q == 4'hf |-> $stable(o_pullup_en);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullups");

  property p_port_upd;
    up_q == 4'hf && $changed(o_io_port_pins_oe)
      |-> $past(i_out_ready) || $past(i_out_ready, 2);
  endproperty
  a_port_upd: assert property (p_port_upd) else $error("port");

  property p_alert_rel;
    $fell(o_change_alert_oe) |-> o_sda_oe;
  endproperty
  a_alert_rel: assert property (p_alert_rel) else $error("alert");
endmodule // pex_core_props

bind pex_core pex_core_props #(.PORTS(PORTS)) u_props (
  .i_ref_clk, .i_rst_b, .i_scl, .i_sda, .o_sda_o, .o_sda_oe,
  .i_serial_rst_b, .i_high_addr_select_pin, .i_low_addr_select_pin,
  .i_io_port_pins, .o_io_port_pins_o, .o_io_port_pins_oe, .o_pullup_en,
  .i_out_ready, .o_change_alert_o, .o_change_alert_oe
);

/* test/pex_master.sv */
`timescale 1ns/1ps
module pex_master (
  // clock and sensed data level
  input wire i_ref_clk,
  input wire i_sda,
  // bus drive, 1 releases to the pull-up
  output reg o_scl,
  output reg o_sda
);
  // clock stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // quarter of the 80 ns bus period, moved just after an edge
  task qtr;
    begin
      repeat (4) @(posedge i_ref_clk);
      #1;
    end
  endtask

  // data falls under a high clock; also serves as repeated start
  task bus_start;
    begin
      o_sda = 1'b1;
      qtr;
      o_scl = 1'b1;
      qtr;
      o_sda = 1'b0;
      qtr;
      o_scl = 1'b0;
      qtr;
    end
  endtask

  // data rises under a high clock
  task bus_stop;
    begin
      o_sda = 1'b0;
      qtr;
      o_scl = 1'b1;
      qtr;
      o_sda = 1'b1;
      qtr;
    end
  endtask

  // data changes only in the low phase
  task bit_io(input b, output r);
    begin
      o_sda = b;
      qtr;
      o_scl = 1'b1;
      qtr;
      r = i_sda;
      qtr;
      o_scl = 1'b0;
      qtr;
    end
  endtask

  // msb first, then the ninth clock with a as our own answer
  task xfer(input [7:0] d, input a, output [7:0] r, output ak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], r[i]);
      end
      bit_io(a, ak);
    end
  endtask
endmodule // pex_master

/* test/pex_core_tb.sv */
`timescale 1ns/1ps
module pex_core_tb;
  reg i_ref_clk;
  reg i_rst_b;
  reg i_serial_rst_b;
  reg [1:0] i_high_addr_select_pin;
  reg [1:0] i_low_addr_select_pin;
  reg i_out_ready;
  reg [7:0] port_ext;
  wire i_scl;
  wire m_sda;
  wire i_sda;
  wire o_sda_o;
  wire o_sda_oe;
  wire o_change_alert_o;
  wire o_change_alert_oe;
  wire [7:0] i_io_port_pins;
  wire [7:0] o_io_port_pins_o;
  wire [7:0] o_io_port_pins_oe;
  wire [7:0] o_pullup_en;
  integer mismatches;
  integer checks;
  integer cyc;
  integer k;
  reg [7:0] got;
  reg ak;
  reg [6:0] addr;

  // pulled-up lines read low when any party pulls
  assign i_sda = m_sda & ~o_sda_oe;
  assign i_io_port_pins = port_ext & ~o_io_port_pins_oe;

  pex_core dut (
    .i_ref_clk, .i_rst_b, .i_scl, .i_sda, .o_sda_o, .o_sda_oe,
    .i_serial_rst_b, .i_high_addr_select_pin, .i_low_addr_select_pin,
    .i_io_port_pins, .o_io_port_pins_o, .o_io_port_pins_oe, .o_pullup_en,
    .i_out_ready, .o_change_alert_o, .o_change_alert_oe
  );
  pex_master m (.i_ref_clk, .i_sda, .o_scl(i_scl), .o_sda(m_sda));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // hang guard, far above the full run
  always @(posedge i_ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end

  task tick(input integer n);
    begin
      repeat (n) @(posedge i_ref_clk);
      #1;
    end
  endtask

  task chk(input [7:0] g, input [7:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // send a byte, e is the expected ninth bit (0 = taken)
  task tx(input [7:0] d, input [7:0] e);
    begin
      m.xfer(d, 1'b1, got, ak);
      chk({7'h0, ak}, e);
    end
  endtask

  task rx(input a, input [7:0] e);
    begin
      m.xfer(8'hff, a, got, ak);
      chk(got, e);
    end
  endtask

  task alert(input [7:0] e);
    begin
      tick(6);
      chk({7'h0, o_change_alert_oe}, e);
    end
  endtask

  // every strap level on both pins, each behind a fresh reset
  task t_straps;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        i_rst_b = 1'b0;
        i_high_addr_select_pin = k[1:0];
        i_low_addr_select_pin = 2'h3 - k[1:0];
        tick(12);
        i_rst_b = 1'b1;
        tick(10);
        addr = {3'b110, k[1:0] ^ 2'h2, 2'h3 - k[1:0]};
        got = {{4{k != 0}}, {4{k != 3}}};
        chk(o_pullup_en, got);
        chk(o_io_port_pins_oe, ~got);
        m.bus_start;
        tx({addr, 1'b0}, 8'h00);
        m.bus_start;
        tx({addr ^ 7'h10, 1'b0}, 8'h01);
        m.bus_stop;
      end
    end
  endtask

  // back-to-back bytes, then a stalled output stage fills the buffer
  task t_write;
    begin
      m.bus_start;
      tx({addr, 1'b0}, 8'h00);
      tx(8'h5a, 8'h00);
      chk(o_io_port_pins_oe, 8'ha5);
      tx(8'hff, 8'h00);
      chk(o_io_port_pins_oe, 8'h00);
      i_out_ready = 1'b0;
      tx(8'h0f, 8'h00);
      tx(8'hf0, 8'h00);
      tx(8'h33, 8'h01);
      chk(o_io_port_pins_oe, 8'h00);
      chk(o_io_port_pins_o | {7'h0, o_change_alert_o | o_sda_o}, 8'h00);
      m.bus_stop;
      i_out_ready = 1'b1;
      tick(6);
      chk(o_io_port_pins_oe, 8'h0f);
      m.bus_start;
      tx({addr, 1'b0}, 8'h00);
      tx(8'hff, 8'h00);
      m.bus_stop;
    end
  endtask

  // snapshot, flags, held alert and multibyte resampling
  task t_read;
    begin
      m.bus_start;
      tx({addr, 1'b1}, 8'h00);
      m.bus_stop;
      alert(8'h00);
      port_ext = 8'hfe;
      alert(8'h01);
      m.bus_start;
      tx({addr, 1'b1}, 8'h00);
      chk({7'h0, o_change_alert_oe}, 8'h00);
      port_ext = 8'hfc;
      rx(1'b0, 8'hfe);
      chk({7'h0, o_change_alert_oe}, 8'h00);
      rx(1'b1, 8'h01);
      m.bus_stop;
      alert(8'h01);
      m.bus_start;
      tx({addr, 1'b1}, 8'h00);
      rx(1'b0, 8'hfc);
      rx(1'b0, 8'h02);
      rx(1'b0, 8'hfc);
      rx(1'b1, 8'h00);
      m.bus_stop;
      alert(8'h00);
    end
  endtask

  // a refused address leaves the alert alone; a write clears it
  task t_nack;
    begin
      port_ext = 8'hfd;
      alert(8'h01);
      m.bus_start;
      tx({addr ^ 7'h20, 1'b1}, 8'h01);
      m.bus_stop;
      alert(8'h01);
      m.bus_start;
      tx({addr, 1'b0}, 8'h00);
      m.bus_stop;
      alert(8'h00);
    end
  endtask

  // serial reset while the address is being acknowledged
  task t_sreset;
    begin
      m.bus_start;
      got = {addr, 1'b1};
      for (k = 7; k >= 0; k = k - 1) begin
        m.bit_io(got[k], ak);
      end
      tick(6);
      chk({7'h0, o_sda_oe}, 8'h01);
      i_serial_rst_b = 1'b0;
      tick(6);
      chk({7'h0, o_sda_oe}, 8'h00);
      i_serial_rst_b = 1'b1;
      tick(4);
      m.bus_start;
      tx({addr, 1'b0}, 8'h00);
      m.bus_stop;
    end
  endtask

  task tally_and_finish;
    begin
      if (mismatches == 0 && checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  initial begin
    mismatches = 0;
    checks = 0;
    cyc = 0;
    i_rst_b = 1'b0;
    i_serial_rst_b = 1'b1;
    i_high_addr_select_pin = 2'h0;
    i_low_addr_select_pin = 2'h0;
    i_out_ready = 1'b1;
    port_ext = 8'hff;
    t_straps;
    t_write;
    t_read;
    t_nack;
    t_sreset;
    tally_and_finish;
  end
endmodule // pex_core_tb
